// >>> hdl/fault_capture.sv
// Fault status and fault address capture registers with an APB slave.
// Assumes the core reports faults as a one-cycle valid with kind, address
// and an escalation flag, all on I_CLK.
//
// Behaviour
// - bus fault with known address sets bus_addr_valid
// - later data violation clears bus_addr_valid
// - software may write bus_addr_valid to zero
// - bus fault in lazy FP sets bit 13
// - stacking bus fault sets bit 12, no address
// - unstacking bus fault sets bit 11, no address
// - imprecise bus error sets bit 10, no address
// - imprecise and precise flags both stay set
// - precise bus error sets bit 9, captures address
// - fetch bus error sets bit 8 on issue
// - mem_addr_valid only while address valid, writable zero
// - memory fault in lazy FP sets bit 5
// - stacking violation sets bit 4, no address
// - unstacking violation sets bit 3, no address
// - data violation sets bit 1, captures address
// - never-execute fetch sets instruction_violation, no address
// - hard fault status is write one to clear
// - escalation sets forced bit 30
// - vector read bus fault sets bit 1
// - memory address holds actual faulting address
// - bus address holds requested address
// - bus byte 15:8, memory byte 7:0 at 0x28
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module fault_capture (
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // Fault report from the core
    input wire logic I_FAULT_VALID,
    input wire fault_capture_pkg::fault_kind_t I_FAULT_KIND,
    input wire logic [31:0] I_FAULT_ADDR,
    input wire logic I_FAULT_ESCALATED,
    // Status levels toward the core
    output logic O_BUS_ADDR_VALID,
    output logic O_MEM_ADDR_VALID,
    output logic O_FORCED
);
    import fault_capture_pkg::*;

    fault_event_if ev ();

    logic [7:0] bus_fault_status;
    logic [7:0] memory_fault_status;
    logic [31:0] hard_fault_status;
    logic [31:0] memory_fault_address;
    logic [31:0] bus_fault_address;
    logic access;
    logic wr;
    logic [7:0] next_bus_status;
    logic [7:0] next_mem_status;
    logic [31:0] next_hard_status;
    logic [31:0] rdata;
    logic mapped;

    // ---------------------------------------------------------------
    // Event registration
    // ---------------------------------------------------------------
    fault_event_decode u_decode (
        .i_clk(I_CLK),
        .i_arst_n(I_ARST_N),
        .i_valid(I_FAULT_VALID),
        .i_kind(I_FAULT_KIND),
        .i_addr(I_FAULT_ADDR),
        .i_escalated(I_FAULT_ESCALATED),
        .ev(ev)
    );

    // ---------------------------------------------------------------
    // APB decode
    // ---------------------------------------------------------------
    // Zero wait states: every access completes in its first access cycle
    assign access = I_PSEL && I_PENABLE;
    assign wr = access && I_PWRITE;
    assign mapped = (I_PADDR == COMBINED_FAULT_STATUS_OFS) || (I_PADDR == HARD_FAULT_STATUS_OFS)
        || (I_PADDR == MEMORY_FAULT_ADDRESS_OFS) || (I_PADDR == BUS_FAULT_ADDRESS_OFS);

    // ---------------------------------------------------------------
    // Combined status next value
    // ---------------------------------------------------------------
    // Software write first, then hardware events on top so a set in the
    // clearing cycle is never lost
    always_comb begin
        next_bus_status = bus_fault_status;
        next_mem_status = memory_fault_status;
        if (wr && I_PADDR == COMBINED_FAULT_STATUS_OFS) begin
            // Status bits are written directly; byte strobes select the half
            if (I_PSTRB[1]) begin
                next_bus_status = I_PWDATA[15:8] & BUS_STATUS_MASK;
            end
            if (I_PSTRB[0]) begin
                next_mem_status = I_PWDATA[7:0] & MEM_STATUS_MASK;
            end
        end
        if (ev.valid) begin
            unique case (ev.kind)
                EV_BUS_LAZY_FP: next_bus_status[BUS_LAZY_FP_ERROR_BIT - BUS_STATUS_LSB] = 1'b1;
                EV_BUS_STACKING: next_bus_status[BUS_STACKING_ERROR_BIT - BUS_STATUS_LSB] = 1'b1;
                EV_BUS_UNSTACKING: next_bus_status[BUS_UNSTACKING_ERROR_BIT - BUS_STATUS_LSB] = 1'b1;
                // Other flags are untouched, so imprecise and precise coexist
                EV_ASYNC_DATA_BUS: next_bus_status[ASYNC_DATA_BUS_ERROR_BIT - BUS_STATUS_LSB] = 1'b1;
                EV_SYNC_DATA_BUS: begin
                    next_bus_status[SYNC_DATA_BUS_ERROR_BIT - BUS_STATUS_LSB] = 1'b1;
                    next_bus_status[BUS_ADDR_VALID_BIT - BUS_STATUS_LSB] = 1'b1;
                end
                EV_FETCH_BUS: next_bus_status[FETCH_BUS_ERROR_BIT - BUS_STATUS_LSB] = 1'b1;
                EV_MEM_LAZY_FP: next_mem_status[MEM_LAZY_FP_ERROR_BIT - MEM_STATUS_LSB] = 1'b1;
                EV_MEM_STACKING: next_mem_status[MEM_STACKING_VIOLATION_BIT - MEM_STATUS_LSB] = 1'b1;
                EV_MEM_UNSTACKING: next_mem_status[MEM_UNSTACKING_VIOLATION_BIT - MEM_STATUS_LSB] = 1'b1;
                EV_DATA_VIOLATION: begin
                    next_mem_status[DATA_VIOLATION_BIT - MEM_STATUS_LSB] = 1'b1;
                    next_mem_status[MEM_ADDR_VALID_BIT - MEM_STATUS_LSB] = 1'b1;
                    // Shared capture: the bus address is no longer trustworthy
                    next_bus_status[BUS_ADDR_VALID_BIT - BUS_STATUS_LSB] = 1'b0;
                end
                EV_INSTRUCTION_VIOLATION: begin
                    next_mem_status[INSTRUCTION_VIOLATION_BIT - MEM_STATUS_LSB] = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Hard fault status next value
    // ---------------------------------------------------------------
    always_comb begin
        next_hard_status = hard_fault_status;
        if (wr && I_PADDR == HARD_FAULT_STATUS_OFS) begin
            // Bit 31 is expected written as zero; a one only clears it
            next_hard_status = hard_fault_status & ~(I_PWDATA & HARD_FAULT_STATUS_MASK);
        end
        if (ev.forced) begin
            next_hard_status[FORCED_BIT] = 1'b1;
        end
        if (ev.valid && ev.kind == EV_VECTOR_READ) begin
            next_hard_status[VECTOR_READ_FAULT_BIT] = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Status registers
    // ---------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            bus_fault_status <= BUS_STATUS_RESET;
            memory_fault_status <= MEM_STATUS_RESET;
            hard_fault_status <= HARD_FAULT_STATUS_RESET;
        end else begin
            bus_fault_status <= next_bus_status;
            memory_fault_status <= next_mem_status;
            hard_fault_status <= next_hard_status;
        end
    end

    // ---------------------------------------------------------------
    // Fault address registers
    // ---------------------------------------------------------------
    // Only precise data faults load an address; a capture beats a write
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            bus_fault_address <= ADDRESS_RESET;
        end else if (ev.valid && ev.kind == EV_SYNC_DATA_BUS) begin
            bus_fault_address <= ev.addr;
        end else if (wr && I_PADDR == BUS_FAULT_ADDRESS_OFS) begin
            bus_fault_address <= I_PWDATA;
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            memory_fault_address <= ADDRESS_RESET;
        end else if (ev.valid && ev.kind == EV_DATA_VIOLATION) begin
            memory_fault_address <= ev.addr;
        end else if (wr && I_PADDR == MEMORY_FAULT_ADDRESS_OFS) begin
            memory_fault_address <= I_PWDATA;
        end
    end

    // ---------------------------------------------------------------
    // Read mux
    // ---------------------------------------------------------------
    always_comb begin
        rdata = 32'h00000000;
        if (I_PADDR == COMBINED_FAULT_STATUS_OFS) begin
            rdata = {16'h0000, bus_fault_status, memory_fault_status};
        end else if (I_PADDR == HARD_FAULT_STATUS_OFS) begin
            rdata = hard_fault_status;
        end else if (I_PADDR == MEMORY_FAULT_ADDRESS_OFS) begin
            rdata = memory_fault_address;
        end else if (I_PADDR == BUS_FAULT_ADDRESS_OFS) begin
            rdata = bus_fault_address;
        end
    end

    // ---------------------------------------------------------------
    // APB outputs, registered
    // ---------------------------------------------------------------
    // Ready is raised in the setup cycle so the access ends in its first
    // access cycle while every output still comes from a flip-flop
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_PREADY <= 1'b0;
            O_PRDATA <= 32'h00000000;
            O_PSLVERR <= 1'b0;
        end else begin
            O_PREADY <= I_PSEL && !I_PENABLE;
            O_PRDATA <= (I_PSEL && !I_PENABLE && !I_PWRITE) ? rdata : 32'h00000000;
            O_PSLVERR <= I_PSEL && !I_PENABLE && !mapped;
        end
    end

    // Status levels mirror the registered flags one cycle later
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_BUS_ADDR_VALID <= 1'b0;
            O_MEM_ADDR_VALID <= 1'b0;
            O_FORCED <= 1'b0;
        end else begin
            O_BUS_ADDR_VALID <= bus_fault_status[BUS_ADDR_VALID_BIT - BUS_STATUS_LSB];
            O_MEM_ADDR_VALID <= memory_fault_status[MEM_ADDR_VALID_BIT - MEM_STATUS_LSB];
            O_FORCED <= hard_fault_status[FORCED_BIT];
        end
    end
endmodule : fault_capture
`default_nettype wire

// >>> hdl/fault_capture_pkg.sv
// Package for the fault status and fault address capture block.
// Assumes a single core clock and an APB slave with 32-bit data.
package fault_capture_pkg;
    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] COMBINED_FAULT_STATUS_OFS = 8'h28;
    localparam logic [7:0] HARD_FAULT_STATUS_OFS = 8'h2c;
    localparam logic [7:0] MEMORY_FAULT_ADDRESS_OFS = 8'h34;
    localparam logic [7:0] BUS_FAULT_ADDRESS_OFS = 8'h38;
    // ---------------------------------------------------------------
    // Field positions in the combined word
    // ---------------------------------------------------------------
    localparam int BUS_ADDR_VALID_BIT = 15;
    localparam int BUS_LAZY_FP_ERROR_BIT = 13;
    localparam int BUS_STACKING_ERROR_BIT = 12;
    localparam int BUS_UNSTACKING_ERROR_BIT = 11;
    localparam int ASYNC_DATA_BUS_ERROR_BIT = 10;
    localparam int SYNC_DATA_BUS_ERROR_BIT = 9;
    localparam int FETCH_BUS_ERROR_BIT = 8;
    localparam int MEM_ADDR_VALID_BIT = 7;
    localparam int MEM_LAZY_FP_ERROR_BIT = 5;
    localparam int MEM_STACKING_VIOLATION_BIT = 4;
    localparam int MEM_UNSTACKING_VIOLATION_BIT = 3;
    localparam int DATA_VIOLATION_BIT = 1;
    localparam int INSTRUCTION_VIOLATION_BIT = 0;
    localparam int BUS_STATUS_LSB = 8;
    localparam int MEM_STATUS_LSB = 0;
    // Hard fault status fields
    localparam int DEBUG_RESERVED_FLAG_BIT = 31;
    localparam int FORCED_BIT = 30;
    localparam int VECTOR_READ_FAULT_BIT = 1;
    // ---------------------------------------------------------------
    // Reset values and masks
    // ---------------------------------------------------------------
    localparam logic [7:0] BUS_STATUS_RESET = 8'h00;
    localparam logic [7:0] MEM_STATUS_RESET = 8'h00;
    localparam logic [31:0] HARD_FAULT_STATUS_RESET = 32'h00000000;
    localparam logic [31:0] ADDRESS_RESET = 32'h00000000;
    localparam logic [7:0] BUS_STATUS_MASK = 8'hbf;
    localparam logic [7:0] MEM_STATUS_MASK = 8'hbb;
    localparam logic [31:0] HARD_FAULT_STATUS_MASK = 32'hc0000002;
    // ---------------------------------------------------------------
    // Fault event kinds reported by the core
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        EV_NONE,
        EV_BUS_LAZY_FP,
        EV_BUS_STACKING,
        EV_BUS_UNSTACKING,
        EV_ASYNC_DATA_BUS,
        EV_SYNC_DATA_BUS,
        EV_FETCH_BUS,
        EV_MEM_LAZY_FP,
        EV_MEM_STACKING,
        EV_MEM_UNSTACKING,
        EV_DATA_VIOLATION,
        EV_INSTRUCTION_VIOLATION,
        EV_VECTOR_READ
    } fault_kind_t;
endpackage : fault_capture_pkg

// >>> hdl/fault_event_if.sv
// Interface carrying one decoded fault event to the status unit.
// Assumes the decoder and the register file share the core clock.
`timescale 1ns/10ps
`default_nettype none
interface fault_event_if;
    logic valid;
    fault_capture_pkg::fault_kind_t kind;
    logic [31:0] addr;
    logic forced;
    modport src (output valid, output kind, output addr, output forced);
    modport dst (input valid, input kind, input addr, input forced);
endinterface : fault_event_if
`default_nettype wire

// >>> hdl/fault_event_decode.sv
// Decoder of the core's fault report into one registered event.
// Assumes the core reports at most one fault kind per cycle.
`timescale 1ns/10ps
`default_nettype none
module fault_event_decode (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_valid,
    input wire fault_capture_pkg::fault_kind_t i_kind,
    input wire logic [31:0] i_addr,
    input wire logic i_escalated,
    fault_event_if.src ev
);
    import fault_capture_pkg::*;

    // ---------------------------------------------------------------
    // One stage of registering, so status updates are glitch free
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ev.valid <= 1'b0;
            ev.kind <= EV_NONE;
            ev.addr <= 32'h00000000;
            ev.forced <= 1'b0;
        end else begin
            ev.valid <= i_valid && (i_kind != EV_NONE);
            ev.kind <= i_kind;
            ev.addr <= i_addr;
            ev.forced <= i_valid && i_escalated;
        end
    end
endmodule : fault_event_decode
`default_nettype wire

// >>> bench/fault_capture_properties.sv
// Concurrent checks on the fault capture block's top-level ports.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module fault_capture_properties (
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_FAULT_VALID,
    input wire fault_capture_pkg::fault_kind_t I_FAULT_KIND,
    input wire logic I_FAULT_ESCALATED,
    input wire logic [31:0] O_PRDATA,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    input wire logic O_BUS_ADDR_VALID,
    input wire logic O_MEM_ADDR_VALID,
    input wire logic O_FORCED
);
    import fault_capture_pkg::*;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);
    // --------------------------------------------------
    // Named steps
    // --------------------------------------------------
    sequence apb_setup; I_PSEL && !I_PENABLE; endsequence
    sequence apb_access; I_PSEL && I_PENABLE; endsequence
    sequence ev_sync; I_FAULT_VALID && I_FAULT_KIND == EV_SYNC_DATA_BUS; endsequence
    sequence ev_data; I_FAULT_VALID && I_FAULT_KIND == EV_DATA_VIOLATION; endsequence
    // --------------------------------------------------
    // Properties
    // --------------------------------------------------
    // Zero wait states, so the answer lands in the first access cycle
    AST_ZERO_WAIT: assert property (apb_setup ##1 apb_access |-> O_PREADY)
        else $error("ready missing in access cycle");
    AST_READY_PULSE: assert property (O_PREADY |=> !O_PREADY)
        else $error("ready held too long");
    AST_SLVERR_ZERO: assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h0)
        else $error("error response without ready or with data");
    AST_BUS_VALID_SET: assert property (ev_sync |-> ##3 O_BUS_ADDR_VALID)
        else $error("bus address valid not set");
    AST_BUS_VALID_CAUSE: assert property ($rose(O_BUS_ADDR_VALID) |->
        $past(I_FAULT_VALID, 3) && $past(I_FAULT_KIND, 3) == EV_SYNC_DATA_BUS)
        else $error("bus address valid rose without cause");
    // Quiet gap keeps a fresh bus capture from masking the drop
    AST_BUS_VALID_DROP: assert property (ev_data ##1 !I_FAULT_VALID [*2] |=> !O_BUS_ADDR_VALID)
        else $error("bus address valid kept after data violation");
    AST_MEM_VALID_SET: assert property (ev_data |-> ##3 O_MEM_ADDR_VALID)
        else $error("memory address valid not set");
    AST_MEM_VALID_CAUSE: assert property ($rose(O_MEM_ADDR_VALID) |->
        $past(I_FAULT_VALID, 3) && $past(I_FAULT_KIND, 3) == EV_DATA_VIOLATION)
        else $error("memory address valid rose without cause");
    AST_FORCED_SET: assert property (I_FAULT_VALID && I_FAULT_ESCALATED |-> ##3 O_FORCED)
        else $error("forced flag not set");
    AST_FORCED_CAUSE: assert property ($rose(O_FORCED) |->
        $past(I_FAULT_VALID, 3) && $past(I_FAULT_ESCALATED, 3))
        else $error("forced flag rose without escalation");
endmodule : fault_capture_properties
bind fault_capture fault_capture_properties u_fault_capture_properties (
    .I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_FAULT_VALID(I_FAULT_VALID), .I_FAULT_KIND(I_FAULT_KIND), .I_FAULT_ESCALATED(I_FAULT_ESCALATED),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .O_BUS_ADDR_VALID(O_BUS_ADDR_VALID), .O_MEM_ADDR_VALID(O_MEM_ADDR_VALID), .O_FORCED(O_FORCED));
`default_nettype wire

// >>> bench/fault_capture_tb.sv
// Self-checking bench for the fault capture block.
// Assumes package, interface, design and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module fault_capture_tb;
    import fault_capture_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic f_valid = 1'b0;
    fault_kind_t f_kind = EV_NONE;
    logic [31:0] f_addr = 32'h0;
    logic f_esc = 1'b0;
    logic bus_av;
    logic mem_av;
    logic forced;
    int bad_count = 0;
    int samples_checked = 0;
    // 50 MHz core clock
    always #10 clk = ~clk;
    fault_capture u_fault_capture (.I_CLK(clk), .I_ARST_N(arst_n), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .I_PSTRB(pstrb), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_FAULT_VALID(f_valid), .I_FAULT_KIND(f_kind), .I_FAULT_ADDR(f_addr),
        .I_FAULT_ESCALATED(f_esc), .O_BUS_ADDR_VALID(bus_av), .O_MEM_ADDR_VALID(mem_av),
        .O_FORCED(forced));
    // --------------------------------------------------
    // Shared tasks
    // --------------------------------------------------
    task automatic stop_test;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // Request held until ready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] w,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= w;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            stop_test();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        logic [31:0] d;
        logic e;
        apb(1'b0, a, 32'h0, d, e);
        chk(name, exp, d);
        chk("slave error", 32'h0, {31'h0, e});
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        logic [31:0] d;
        logic e;
        apb(1'b1, a, w, d, e);
    endtask : wr
    // One-cycle fault report, then time for the mirrors to settle
    task automatic fault(input fault_kind_t k, input logic [31:0] a, input logic esc);
        @(posedge clk);
        f_valid <= 1'b1;
        f_kind <= k;
        f_addr <= a;
        f_esc <= esc;
        @(posedge clk);
        f_valid <= 1'b0;
        f_esc <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : fault
    // --------------------------------------------------
    // Scenarios
    // --------------------------------------------------
    task automatic test_reset_values;
        rd(8'h28, 32'h0, "combined status");
        rd(8'h2c, 32'h0, "hard status");
    endtask : test_reset_values
    // Each of the 11 combined-status kinds in turn; flags accumulate, only two kinds capture
    task automatic test_event_table;
        fault_kind_t kinds [11] = '{EV_BUS_LAZY_FP, EV_BUS_STACKING, EV_BUS_UNSTACKING,
            EV_ASYNC_DATA_BUS, EV_FETCH_BUS, EV_SYNC_DATA_BUS, EV_MEM_LAZY_FP, EV_MEM_STACKING,
            EV_MEM_UNSTACKING, EV_INSTRUCTION_VIOLATION, EV_DATA_VIOLATION};
        logic [15:0] bits [11] = '{16'h2000, 16'h1000, 16'h0800, 16'h0400, 16'h0100,
            16'h8200, 16'h0020, 16'h0010, 16'h0008, 16'h0001, 16'h0082};
        logic [31:0] cfs;
        logic [31:0] bfa;
        logic [31:0] mfa;
        logic [31:0] a;
        cfs = 32'h0;
        bfa = 32'h0;
        mfa = 32'h0;
        for (int i = 0; i < 11; i++) begin
            a = 32'h2000_0001 + 32'(i * 16);
            fault(kinds[i], a, 1'b0);
            cfs = cfs | {16'h0, bits[i]};
            if (kinds[i] == EV_SYNC_DATA_BUS) begin
                bfa = a;
            end
            if (kinds[i] == EV_DATA_VIOLATION) begin
                mfa = a;
                cfs[15] = 1'b0;
            end
            rd(8'h28, cfs, "combined status");
            rd(8'h38, bfa, "bus address");
            rd(8'h34, mfa, "memory address");
            chk("bus valid", {31'h0, cfs[15]}, {31'h0, bus_av});
            chk("mem valid", {31'h0, cfs[7]}, {31'h0, mem_av});
        end
    endtask : test_event_table
    task automatic test_software_clear;
        wr(8'h28, 32'h0000_3f3b);
        rd(8'h28, 32'h0000_3f3b, "combined status");
        fault(EV_SYNC_DATA_BUS, 32'h3000_0002, 1'b0);
        rd(8'h28, 32'h0000_bf3b, "combined status");
        wr(8'h28, 32'hffff_7f7f);
        rd(8'h28, 32'h0000_3f3b, "combined status");
        chk("bus valid", 32'h0, {31'h0, bus_av});
        wr(8'h28, 32'h0);
        rd(8'h28, 32'h0, "combined status");
    endtask : test_software_clear
    // Writing zeros or reserved ones must not disturb set flags
    task automatic test_hard_fault;
        fault(EV_VECTOR_READ, 32'h0, 1'b1);
        rd(8'h2c, 32'h4000_0002, "hard status");
        chk("forced", 32'h1, {31'h0, forced});
        wr(8'h2c, 32'h3fff_fffd);
        rd(8'h2c, 32'h4000_0002, "hard status");
        wr(8'h2c, 32'h0000_0002);
        rd(8'h2c, 32'h4000_0000, "hard status");
        wr(8'h2c, 32'h4000_0000);
        rd(8'h2c, 32'h0, "hard status");
        chk("forced", 32'h0, {31'h0, forced});
    endtask : test_hard_fault
    task automatic test_unmapped_and_address;
        logic [31:0] d;
        logic e;
        apb(1'b1, 8'h30, 32'hffff_ffff, d, e);
        chk("write error", 32'h1, {31'h0, e});
        apb(1'b0, 8'h30, 32'h0, d, e);
        chk("read error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, d);
        wr(8'h34, 32'h1234_5678);
        rd(8'h34, 32'h1234_5678, "memory address");
        wr(8'h38, 32'h8765_4321);
        rd(8'h38, 32'h8765_4321, "bus address");
    endtask : test_unmapped_and_address
    // Byte strobes pick one status byte; valid bits kept low on purpose
    task automatic test_byte_strobes;
        pstrb <= 4'h1;
        wr(8'h28, 32'h0000_7f7f);
        rd(8'h28, 32'h0000_003b, "combined status");
        pstrb <= 4'h2;
        wr(8'h28, 32'h0000_7f00);
        rd(8'h28, 32'h0000_3f3b, "combined status");
        pstrb <= 4'hf;
        wr(8'h28, 32'h0);
        rd(8'h28, 32'h0, "combined status");
    endtask : test_byte_strobes
    // --------------------------------------------------
    // Main sequence and watchdog
    // --------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        test_reset_values();
        test_event_table();
        test_software_clear();
        test_hard_fault();
        test_unmapped_and_address();
        test_byte_strobes();
        stop_test();
    end
    // About 270 cycles expected; 5000 leaves ample margin
    initial begin
        #100000;
        bad_count++;
        stop_test();
    end
endmodule : fault_capture_tb
`default_nettype wire
